// file: core/sfh_core.sv
/*
 * pause handling, status word, status-write permission and protection map
 * of a serial flash slave; assumes serial pins are asynchronous to i_clk,
 * engine inputs come from same-clock logic.
 */
`timescale 1ns/1ps
module sfh_core (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_si,
    input wire logic i_pause_b,
    input wire logic i_wp_b,
    input wire logic i_engine_busy,
    input wire logic i_engine_done,
    input wire logic i_seq_active,
    input wire logic i_seq_top,
    input wire logic [15:0] i_chk_addr,
    input wire logic i_chk_chip,
    output logic o_so,
    output logic o_so_oe_b,
    output logic o_paused,
    output logic [7:0] o_status,
    output logic o_chk_ok
);
    logic [4:0] sync_q;
    logic cs_s, sck_s, si_s, pause_s, wp_s;
    logic sck_prev;
    logic paused;
    logic sck_rise, sck_fall, byte_done;
    logic [2:0] bit_cnt;
    logic [7:0] rx_sh;
    logic [7:0] rx_byte;
    logic [2:0] out_cnt;
    logic [7:0] tx_sh;
    sfh_pkg::sfh_state_t state;
    logic write_enable_latch, busy, seq_flag, lockdown;
    logic [1:0] level;
    logic write_status_cmd_commit, write_status_cmd_ok;
    logic [7:0] status_now;

    function automatic logic in_protected(input logic [15:0] addr, input logic [1:0] lvl);
        case (lvl)
            2'h1: in_protected = addr >= sfh_pkg::PROT_BASE_L1;
            2'h2: in_protected = addr >= sfh_pkg::PROT_BASE_L2;
            2'h3: in_protected = addr >= sfh_pkg::PROT_BASE_L3;
            default: in_protected = 1'b0;
        endcase
    endfunction : in_protected

    sfh_sync #(
        .W(sfh_pkg::SYNC_W),
        .INIT(5'h19)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async({i_cs_b, i_pause_b, i_wp_b, i_sck, i_si}),
        .o_sync(sync_q)
    );
    assign {cs_s, pause_s, wp_s, sck_s, si_s} = sync_q;

    // pause tracking
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            paused <= 1'b0;
        end else if (cs_s) begin
            paused <= 1'b0;
        end else if (!sck_s) begin
            paused <= !pause_s;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_s;
        end
    end

    assign sck_rise = sck_s && !sck_prev && !cs_s && !paused;
    assign sck_fall = !sck_s && sck_prev && !cs_s && !paused;
    assign byte_done = sck_rise && (bit_cnt == sfh_pkg::LAST_BIT);
    assign rx_byte = {rx_sh[6:0], si_s};

    // input shifter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bit_cnt <= 3'h0;
            rx_sh <= 8'h00;
        end else if (cs_s) begin
            bit_cnt <= 3'h0;
        end else if (sck_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            rx_sh <= rx_byte;
        end
    end

    // transfer phase
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= sfh_pkg::SFH_ST_OPCODE;
        end else if (cs_s) begin
            state <= sfh_pkg::SFH_ST_OPCODE;
        end else if (byte_done) begin
            case (state)
                sfh_pkg::SFH_ST_OPCODE: begin
                    case (rx_byte)
                        sfh_pkg::OPC_WRITE_STATUS: state <= sfh_pkg::SFH_ST_WRDATA;
                        sfh_pkg::OPC_READ_STATUS: state <= sfh_pkg::SFH_ST_RDOUT;
                        default: state <= sfh_pkg::SFH_ST_IGNORE;
                    endcase
                end
                sfh_pkg::SFH_ST_WRDATA: state <= sfh_pkg::SFH_ST_IGNORE;
                sfh_pkg::SFH_ST_RDOUT: state <= sfh_pkg::SFH_ST_RDOUT;
                sfh_pkg::SFH_ST_IGNORE: state <= sfh_pkg::SFH_ST_IGNORE;
                default: state <= sfh_pkg::SFH_ST_IGNORE;
            endcase
        end
    end

    // status write permission
    assign write_status_cmd_ok = wp_s || !lockdown;
    assign write_status_cmd_commit = byte_done && (state == sfh_pkg::SFH_ST_WRDATA);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            level <= sfh_pkg::RST_PROTECT_LEVEL;
            lockdown <= sfh_pkg::RST_LOCKDOWN;
        end else if (write_status_cmd_commit && write_status_cmd_ok) begin
            level <= {rx_byte[sfh_pkg::BIT_BP_HI], rx_byte[sfh_pkg::BIT_BP_LO]};
            lockdown <= rx_byte[sfh_pkg::BIT_LOCK];
        end
    end

    // write-enable latch
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            write_enable_latch <= sfh_pkg::RST_WEL;
        end else if (i_engine_done || i_seq_top) begin
            write_enable_latch <= 1'b0;
        end else if (byte_done && state == sfh_pkg::SFH_ST_OPCODE) begin
            if (rx_byte == sfh_pkg::OPC_WRITE_DISABLE) begin
                write_enable_latch <= 1'b0;
            end else if (rx_byte == sfh_pkg::OPC_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1;
            end
        end
    end

    // engine state mirrors
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy <= 1'b0;
            seq_flag <= 1'b0;
        end else begin
            busy <= i_engine_busy;
            seq_flag <= i_seq_active;
        end
    end

    assign status_now = {lockdown, seq_flag, 2'b00, level, write_enable_latch, busy};

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_status <= {sfh_pkg::RST_LOCKDOWN, 3'h0, sfh_pkg::RST_PROTECT_LEVEL, 2'h0};
        end else begin
            o_status <= status_now;
        end
    end

    // status readout
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_cnt <= 3'h0;
            tx_sh <= 8'h00;
            o_so <= 1'b0;
        end else if (cs_s) begin
            out_cnt <= 3'h0;
        end else if (sck_fall && state == sfh_pkg::SFH_ST_RDOUT) begin
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h0) begin
                o_so <= status_now[7];
                tx_sh <= {status_now[6:0], 1'b0};
            end else begin
                o_so <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_so_oe_b <= 1'b1;
            o_paused <= 1'b0;
        end else begin
            o_so_oe_b <= !(state == sfh_pkg::SFH_ST_RDOUT && !paused && !cs_s);
            o_paused <= paused;
        end
    end

    // program/erase admission
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_chk_ok <= 1'b0;
        end else if (i_chk_chip) begin
            o_chk_ok <= write_enable_latch && !busy && (level == 2'h0);
        end else begin
            o_chk_ok <= write_enable_latch && !busy && !in_protected(i_chk_addr, level);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    AST_DESELECT_CLEARS: assert property (cs_s |=> !paused)
        else $error("pause survived deselect");
    AST_ENTER_LOW: assert property (!cs_s && !sck_s && !pause_s |=> paused)
        else $error("pause not entered");
    AST_EXIT_LOW: assert property (!cs_s && !sck_s && pause_s |=> !paused)
        else $error("pause not left");
    AST_DEFER_HIGH: assert property (!cs_s && sck_s |=> $stable(paused))
        else $error("pause changed while clock high");
    AST_SO_FLOAT: assert property (paused |=> o_so_oe_b)
        else $error("output driven while paused");
    AST_FROZEN: assert property (paused && !cs_s |=> $stable(bit_cnt) && $stable(rx_sh))
        else $error("shifter moved while paused");
    AST_LOCKED: assert property (write_status_cmd_commit && !wp_s && lockdown |=> $stable(level) && lockdown)
        else $error("locked status altered");
    AST_WEL_CLEAR: assert property (i_engine_done |=> !write_enable_latch ##1 !o_status[1])
        else $error("latch not cleared");
    AST_CHIP_GUARD: assert property (i_chk_chip && level != 2'h0 |=> !o_chk_ok)
        else $error("chip erase admitted");
    AST_RSVD_ZERO: assert property (o_status[5:4] == 2'h0)
        else $error("reserved bits set");

    COV_PAUSE: cover property ($rose(paused) ##[1:50] $fell(paused));
    COV_WRITE_STATUS_CMD: cover property (write_status_cmd_commit && write_status_cmd_ok);
    COV_RDOUT: cover property (state == sfh_pkg::SFH_ST_RDOUT && !o_so_oe_b);
endmodule : sfh_core

// file: core/sfh_pkg.sv
/*
 * constants, state codes and reset values shared by the flash pause and
 * write-protection logic; assumes one 10 MHz system clock.
 */
package sfh_pkg;
    // opcodes
    localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OPC_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OPC_READ_STATUS = 8'h05;
    localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
    // status bit positions
    localparam int BIT_BUSY = 0;
    localparam int BIT_WEL = 1;
    localparam int BIT_BP_LO = 2;
    localparam int BIT_BP_HI = 3;
    localparam int BIT_SEQ = 6;
    localparam int BIT_LOCK = 7;
    // power-up values
    localparam logic [1:0] RST_PROTECT_LEVEL = 2'h3;
    localparam logic RST_LOCKDOWN = 1'b0;
    localparam logic RST_WEL = 1'b0;
    // protected area lower bounds per level
    localparam logic [15:0] PROT_BASE_L1 = 16'hC000;
    localparam logic [15:0] PROT_BASE_L2 = 16'h8000;
    localparam logic [15:0] PROT_BASE_L3 = 16'h0000;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int SYNC_W = 5;

    typedef enum logic [3:0] {
        SFH_ST_OPCODE = 4'h1,
        SFH_ST_WRDATA = 4'h2,
        SFH_ST_RDOUT = 4'h4,
        SFH_ST_IGNORE = 4'h8
    } sfh_state_t;
endpackage : sfh_pkg

// file: core/sfh_sync.sv
/*
 * two-flop synchroniser for pins from outside the clock domain;
 * assumes inputs are quasi-static relative to i_clk.
 */
`timescale 1ns/1ps
module sfh_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta <= INIT;
            o_sync <= INIT;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : sfh_sync

// file: test/sfh_host.sv
/*
 * spi host model: select, serial clock, serial data in, read-back byte.
 * assumes mode 0 (clock idles low) and a 10 MHz bench clock on i_clk.
 */
`timescale 1ns/1ps
module sfh_host (
    input wire logic i_clk,
    input wire logic i_so,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_si,
    output logic [7:0] o_rx
);
    initial begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
        o_rx = 8'h00;
    end
    task automatic lvl(input logic v, input int n);
        @(posedge i_clk);
        o_sck <= v;
        repeat (n) @(posedge i_clk);
    endtask : lvl
    task automatic sel();
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask : sel
    task automatic desel();
        lvl(1'b0, 4);
        o_cs_b <= 1'b1;
        o_si <= ~o_si;
        repeat (4) @(posedge i_clk);
    endtask : desel
    // one 800 ns clock period per bit
    task automatic xfer(input logic [7:0] tx, input int hi = 7, input int lo = 0);
        for (int i = hi; i >= lo; i--) begin
            lvl(1'b0, 1);
            o_si <= tx[i];
            repeat (2) @(posedge i_clk);
            lvl(1'b1, 1);
            o_rx[i] <= i_so;
            repeat (2) @(posedge i_clk);
        end
    endtask : xfer
endmodule : sfh_host

// file: test/tb_spi_flash_hold_and_write_protect.sv
/*
 * self-checking bench for the pause and protection core; the host model
 * drives the link, the bench drives pause, protect and engine inputs.
 */
`timescale 1ns/1ps
module tb_spi_flash_hold_and_write_protect;
    logic i_clk, i_rst_b, cs_b, sck, si, pause_b, wp_b, busy, done, seq_act, seq_top;
    logic chip, so, so_oe_b, paused, ok;
    logic [15:0] addr;
    logic [7:0] status, rx;
    logic [15:0] base [4] = '{16'hFFFF, 16'hC000, 16'h8000, 16'h0000};
    int n_errors = 0;
    int comparisons = 0;
    sfh_core i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck), .i_si(si),
        .i_pause_b(pause_b), .i_wp_b(wp_b), .i_engine_busy(busy), .i_engine_done(done),
        .i_seq_active(seq_act), .i_seq_top(seq_top), .i_chk_addr(addr), .i_chk_chip(chip),
        .o_so(so), .o_so_oe_b(so_oe_b), .o_paused(paused), .o_status(status), .o_chk_ok(ok));
    sfh_host i_host (.i_clk(i_clk), .i_so(so), .o_cs_b(cs_b), .o_sck(sck), .o_si(si),
        .o_rx(rx));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic finish_test();
        $display("comparisons %0d errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic after(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : after
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic two);
        i_host.sel();
        i_host.xfer(op);
        if (two) begin
            i_host.xfer(d);
        end
        i_host.desel();
        after(1);
    endtask : cmd
    task automatic read_status_cmd(input logic [7:0] e);
        i_host.sel();
        i_host.xfer(sfh_pkg::OPC_READ_STATUS);
        i_host.xfer(8'h00);
        after(1);
        chk("serial status", e, rx);
        chk("so_oe_b reading", 8'h00, {7'h0, so_oe_b});
        i_host.xfer(8'h00);
        after(1);
        chk("serial status repeat", e, rx);
        i_host.desel();
    endtask : read_status_cmd
    task automatic probe(input logic [15:0] a, input logic c, input logic e);
        @(posedge i_clk);
        addr <= a;
        chip <= c;
        after(2);
        chk("chk_ok", {7'h0, e}, {7'h0, ok});
    endtask : probe
    initial begin
        i_rst_b = 1'b0;
        {pause_b, wp_b} = 2'h3;
        {busy, done, seq_act, seq_top, chip} = 5'h00;
        addr = 16'h0000;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        after(3);
        chk("status", 8'h0C, status);
        chk("so_oe_b", 8'h01, {7'h0, so_oe_b});
        read_status_cmd(8'h0C);
        cmd(sfh_pkg::OPC_WRITE_STATUS, 8'hF3, 1'b1);
        chk("status", 8'h80, status);
        @(posedge i_clk);
        wp_b <= 1'b0;
        cmd(sfh_pkg::OPC_WRITE_STATUS, 8'h0C, 1'b1);
        chk("status", 8'h80, status);
        @(posedge i_clk);
        wp_b <= 1'b1;
        for (int lv = 0; lv < 4; lv++) begin
            cmd(sfh_pkg::OPC_WRITE_STATUS, {4'h0, lv[1:0], 2'h0}, 1'b1);
            cmd(sfh_pkg::OPC_WRITE_ENABLE, 8'h00, 1'b0);
            chk("status", {4'h0, lv[1:0], 2'h2}, status);
            probe(base[lv], 1'b0, lv == 0);
            probe(base[lv] - 16'h1, 1'b0, lv != 3);
            probe(16'h0000, 1'b1, lv == 0);
            @(posedge i_clk);
            done <= (lv == 1);
            seq_top <= (lv == 2);
            @(posedge i_clk);
            done <= 1'b0;
            seq_top <= 1'b0;
            if (lv[0] == lv[1]) begin
                cmd(sfh_pkg::OPC_WRITE_DISABLE, 8'h00, 1'b0);
            end
            after(2);
            chk("status", {4'h0, lv[1:0], 2'h0}, status);
            probe(16'h0000, 1'b0, 1'b0);
        end
        @(posedge i_clk);
        wp_b <= 1'b0;
        cmd(sfh_pkg::OPC_WRITE_STATUS, 8'h84, 1'b1);
        chk("status", 8'h84, status);
        cmd(sfh_pkg::OPC_WRITE_STATUS, 8'h00, 1'b1);
        chk("status", 8'h84, status);
        @(posedge i_clk);
        busy <= 1'b1;
        seq_act <= 1'b1;
        after(3);
        chk("status", 8'hC5, status);
        read_status_cmd(8'hC5);
        @(posedge i_clk);
        busy <= 1'b0;
        seq_act <= 1'b0;
        i_host.sel();
        i_host.xfer(sfh_pkg::OPC_READ_STATUS);
        i_host.xfer(8'h00, 7, 4);
        pause_b <= 1'b0;
        after(3);
        chk("paused", 8'h00, {7'h0, paused});
        i_host.lvl(1'b0, 6);
        after(0);
        chk("paused", 8'h01, {7'h0, paused});
        chk("so_oe_b", 8'h01, {7'h0, so_oe_b});
        i_host.lvl(1'b1, 4);
        i_host.lvl(1'b0, 4);
        i_host.lvl(1'b1, 1);
        pause_b <= 1'b1;
        after(4);
        chk("paused", 8'h01, {7'h0, paused});
        i_host.lvl(1'b0, 6);
        after(0);
        chk("paused", 8'h00, {7'h0, paused});
        i_host.xfer(8'h00, 3, 0);
        after(1);
        chk("serial status", 8'h84, rx);
        i_host.desel();
        i_host.sel();
        i_host.xfer(sfh_pkg::OPC_WRITE_STATUS, 7, 4);
        pause_b <= 1'b0;
        i_host.lvl(1'b0, 6);
        after(0);
        chk("paused", 8'h01, {7'h0, paused});
        i_host.desel();
        after(0);
        chk("paused", 8'h00, {7'h0, paused});
        @(posedge i_clk);
        pause_b <= 1'b1;
        read_status_cmd(8'h84);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        $display("[FAIL] watchdog expected finished seen timeout");
        finish_test();
    end
endmodule : tb_spi_flash_hold_and_write_protect
